// ---- hw/dmx_regs.svh ----
// Constants for the data-move executor: opcodes, addresses, timing
`ifndef DMX_REGS_SVH
`define DMX_REGS_SVH

`define DMX_CLK_PERIOD_NS 10
`define DMX_SLOT_NS 40
`define DMX_SLOT_CLKS (`DMX_SLOT_NS / `DMX_CLK_PERIOD_NS)
`define DMX_PHASE_W 2
`define DMX_SLOTS_PER_CYCLE 2

`define DMX_OP_STORE_CARRY 8'h92
`define DMX_OP_DIR_IMM 8'h75
`define DMX_OP_DIR_IND 7'h43
`define DMX_OP_DIR_ACC 8'hF5
`define DMX_OP_DIR_REG 5'h11
`define DMX_OP_DIR_DIR 8'h85
`define DMX_OP_CODE_PTR 8'h93
`define DMX_OP_CODE_PC 8'h83
`define DMX_OP_XWR_PTR 8'hF0
`define DMX_OP_XWR_REG 7'h79

`define DMX_P2_LATCH_ADDR 8'hA0
`define DMX_BIT_AREA_HI 4'h2

`define DMX_ACC_RST 8'h00
`define DMX_PTR_RST 16'h0000
`define DMX_PC_RST 16'h0000
`define DMX_BYTE_RST 8'h00

`endif

// ---- hw/dmx_pkg.sv ----
// Types shared by the data-move executor
package dmx_pkg;
  typedef enum logic {ST_IDLE, ST_RUN} dmx_state_t;
  typedef enum logic [3:0] {
    K_NOP, K_STC, K_DIRIMM, K_DIRIND, K_DIRA, K_DIRREG, K_DIRDIR,
    K_CPTR, K_CPC, K_XPTR, K_XREG
  } dmx_kind_t;
  typedef enum logic [1:0] {SL_FETCH, SL_CODE, SL_XWR, SL_NONE} dmx_slot_t;
endpackage

// ---- hw/dmx_phase_div.sv ----
// Divider giving the bus phase inside one slot and a slot-end pulse
`timescale 1ns/1ps
`include "dmx_regs.svh"
module dmx_phase_div (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic en_in,
  output logic [`DMX_PHASE_W-1:0] phase_out,
  output logic end_out
);
  localparam int PW = `DMX_PHASE_W;
  localparam logic [PW-1:0] LAST = PW'(`DMX_SLOT_CLKS - 1);
  logic [`DMX_PHASE_W-1:0] cnt_q;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else if (!en_in || cnt_q == LAST) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign phase_out = cnt_q;
  assign end_out = en_in && cnt_q == LAST;
endmodule

// ---- hw/dmx_iram.sv ----
// Internal data memory: three read ports, one write port
`timescale 1ns/1ps
module dmx_iram (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [7:0] waddr_in,
  input wire logic [7:0] wdata_in,
  input wire logic [7:0] addr_a_in,
  input wire logic [7:0] addr_b_in,
  input wire logic [7:0] addr_c_in,
  output logic [7:0] rdata_a_out,
  output logic [7:0] rdata_b_out,
  output logic [7:0] rdata_c_out
);
  logic [7:0] mem_q [0:255];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  assign rdata_a_out = mem_q[addr_a_in];
  assign rdata_b_out = mem_q[addr_b_in];
  assign rdata_c_out = mem_q[addr_c_in];
endmodule

// ---- hw/dmx_core.sv ----
// Executor for the data-move group with its external bus on ports 0 and 2
// Notes on behaviour
// RQ1: 92h stores carry into bit; 2 bytes, 2 cycles
// RQ2: 75h writes immediate to direct; 3 bytes, 2 cycles
// RQ3: Indirect via working register 0/1 to direct
// RQ4: F5h copies accumulator to direct; one cycle
// RQ5: 10001rrr copies working register to direct
// RQ6: Direct to direct copy, 3 bytes, 2 cycles
// RQ7: 93h loads code byte at pointer plus accumulator
// RQ8: Lookup address high on port 2, low on port 0
// RQ9: 83h looks up at incremented counter plus accumulator
// RQ10: F0h writes accumulator externally at pointer address
// RQ11: 1111001r writes externally; port 2 latch unchanged
// RQ12: Accumulator loads refresh parity; others keep flags
// RQ13: External memory answers within the access slot
`timescale 1ns/1ps
`include "dmx_regs.svh"
module dmx_core (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic load_in,
  input wire logic [7:0] load_acc_in,
  input wire logic [15:0] load_ptr_in,
  input wire logic [15:0] load_pc_in,
  input wire logic load_carry_in,
  input wire logic ram_we_in,
  input wire logic [7:0] ram_addr_in,
  input wire logic [7:0] ram_wdata_in,
  output logic [7:0] ram_rdata_out,
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic p0_oe_n_out,
  output logic [7:0] p2_out,
  output logic ale_out,
  output logic code_rd_n_out,
  output logic data_wr_n_out,
  output logic [7:0] acc_out,
  output logic carry_out,
  output logic parity_out,
  output logic [15:0] sixteen_bit_pointer_out,
  output logic [15:0] pc_out,
  output logic busy_out
);
  localparam int SC = `DMX_SLOT_CLKS;
  localparam int SPC = `DMX_SLOTS_PER_CYCLE;

  dmx_pkg::dmx_state_t state_q;
  dmx_pkg::dmx_kind_t kind;
  dmx_pkg::dmx_slot_t slot_kind;
  logic [1:0] slot_q;
  logic [7:0] op_q, b1_q, b2_q, acc_q, xcap_q, dbg_q;
  logic [15:0] ptr_q, pc_q, bus_addr;
  logic car_q, par_q;
  logic [1:0] nbytes, ncyc;
  logic [2:0] nslots;
  logic [`DMX_PHASE_W-1:0] phase;
  logic slot_end, run_act, exec, last_slot;
  logic [2:0] ridx;
  logic [7:0] bit_byte, rd_a, rd_b, rd_c, addr_b;
  logic ram_we;
  logic [7:0] ram_waddr, ram_wdata, bit_new;
  logic [7:0] p0_q, p2_q;
  logic oe_n_q, ale_q, crd_n_q, wr_n_q;
  logic [7:0] icnt_q;

  function automatic dmx_pkg::dmx_kind_t dec_kind(input logic [7:0] op);
    dec_kind = dmx_pkg::K_NOP;
    if (op == `DMX_OP_STORE_CARRY) dec_kind = dmx_pkg::K_STC; // RQ1
    if (op == `DMX_OP_DIR_IMM) dec_kind = dmx_pkg::K_DIRIMM; // RQ2
    if (op[7:1] == `DMX_OP_DIR_IND) dec_kind = dmx_pkg::K_DIRIND; // RQ3
    if (op == `DMX_OP_DIR_ACC) dec_kind = dmx_pkg::K_DIRA; // RQ4
    if (op[7:3] == `DMX_OP_DIR_REG) dec_kind = dmx_pkg::K_DIRREG; // RQ5
    if (op == `DMX_OP_DIR_DIR) dec_kind = dmx_pkg::K_DIRDIR; // RQ6
    if (op == `DMX_OP_CODE_PTR) dec_kind = dmx_pkg::K_CPTR; // RQ7
    if (op == `DMX_OP_CODE_PC) dec_kind = dmx_pkg::K_CPC; // RQ9
    if (op == `DMX_OP_XWR_PTR) dec_kind = dmx_pkg::K_XPTR; // RQ10
    if (op[7:1] == `DMX_OP_XWR_REG) dec_kind = dmx_pkg::K_XREG; // RQ11
  endfunction

  assign kind = dec_kind(op_q);

  // Length in bytes and machine cycles of each kind
  always_comb begin
    nbytes = 2'd1;
    ncyc = 2'd2;
    unique case (kind)
      dmx_pkg::K_NOP: ncyc = 2'd1;
      dmx_pkg::K_STC, dmx_pkg::K_DIRIND, dmx_pkg::K_DIRREG: nbytes = 2'd2;
      dmx_pkg::K_DIRA: begin
        nbytes = 2'd2; // RQ4
        ncyc = 2'd1; // RQ4
      end
      dmx_pkg::K_DIRIMM, dmx_pkg::K_DIRDIR: nbytes = 2'd3;
      dmx_pkg::K_CPTR, dmx_pkg::K_CPC, dmx_pkg::K_XPTR, dmx_pkg::K_XREG: nbytes = 2'd1;
    endcase
  end

  assign nslots = 3'(ncyc * SPC);
  assign last_slot = {1'b0, slot_q} == nslots - 3'd1;
  assign run_act = state_q == dmx_pkg::ST_RUN;
  assign exec = slot_end && last_slot && slot_q != 2'd0;

  // Bus use of the current slot
  always_comb begin
    slot_kind = dmx_pkg::SL_NONE;
    if (slot_q == 2'd0 || {1'b0, slot_q} < {1'b0, nbytes}) begin
      slot_kind = dmx_pkg::SL_FETCH;
    end else if (slot_q == 2'd2) begin
      if (kind == dmx_pkg::K_CPTR || kind == dmx_pkg::K_CPC) begin
        slot_kind = dmx_pkg::SL_CODE;
      end else if (kind == dmx_pkg::K_XPTR || kind == dmx_pkg::K_XREG) begin
        slot_kind = dmx_pkg::SL_XWR;
      end
    end
  end

  assign ridx = (kind == dmx_pkg::K_DIRREG) ? op_q[2:0] : {2'b00, op_q[0]};
  assign bit_byte = b1_q[7] ? {b1_q[7:3], 3'b000} : {`DMX_BIT_AREA_HI, b1_q[6:3]};

  always_comb begin
    bus_addr = pc_q;
    if (slot_kind == dmx_pkg::SL_CODE) begin
      bus_addr = (kind == dmx_pkg::K_CPTR) ? ptr_q + {8'h00, acc_q} : pc_q + {8'h00, acc_q}; // RQ9
    end else if (slot_kind == dmx_pkg::SL_XWR) begin
      bus_addr = (kind == dmx_pkg::K_XPTR) ? ptr_q : {rd_c, rd_a}; // RQ11
    end
  end

  always_comb begin
    addr_b = b1_q;
    if (!run_act) begin
      addr_b = ram_addr_in;
    end else if (kind == dmx_pkg::K_STC) begin
      addr_b = bit_byte;
    end else if (kind == dmx_pkg::K_DIRIND) begin
      addr_b = rd_a; // RQ3
    end
  end

  always_comb begin
    bit_new = rd_b;
    bit_new[b1_q[2:0]] = car_q; // RQ1
  end

  // Write port: executing move, or loader while idle
  always_comb begin
    ram_we = 1'b0;
    ram_waddr = b1_q;
    ram_wdata = rd_b;
    if (!run_act) begin
      ram_we = ram_we_in;
      ram_waddr = ram_addr_in;
      ram_wdata = ram_wdata_in;
    end else if (exec) begin
      unique case (kind)
        dmx_pkg::K_STC: begin
          ram_we = 1'b1;
          ram_waddr = bit_byte;
          ram_wdata = bit_new;
        end
        dmx_pkg::K_DIRIMM: begin
          ram_we = 1'b1;
          ram_wdata = b2_q; // RQ2
        end
        dmx_pkg::K_DIRIND: ram_we = 1'b1; // RQ3
        dmx_pkg::K_DIRA: begin
          ram_we = 1'b1;
          // One-cycle move: the address byte arrives on the same edge
          ram_waddr = p0_in; // RQ4
          ram_wdata = acc_q; // RQ4
        end
        dmx_pkg::K_DIRREG: begin
          ram_we = 1'b1;
          ram_wdata = rd_a; // RQ5
        end
        dmx_pkg::K_DIRDIR: begin
          ram_we = 1'b1;
          ram_waddr = b2_q; // RQ6
        end
        dmx_pkg::K_NOP, dmx_pkg::K_CPTR, dmx_pkg::K_CPC, dmx_pkg::K_XPTR,
        dmx_pkg::K_XREG: ram_we = 1'b0;
      endcase
    end
  end

  dmx_phase_div u_div (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .en_in(run_act),
    .phase_out(phase),
    .end_out(slot_end)
  );

  dmx_iram u_ram (
    .clk_in(clk_in),
    .we_in(ram_we),
    .waddr_in(ram_waddr),
    .wdata_in(ram_wdata),
    .addr_a_in({5'b00000, ridx}),
    .addr_b_in(addr_b),
    .addr_c_in(`DMX_P2_LATCH_ADDR),
    .rdata_a_out(rd_a),
    .rdata_b_out(rd_b),
    .rdata_c_out(rd_c)
  );

  // Run control and slot sequencing
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= dmx_pkg::ST_IDLE;
      slot_q <= 2'd0;
    end else if (!run_act) begin
      slot_q <= 2'd0;
      if (run_in) state_q <= dmx_pkg::ST_RUN;
    end else if (slot_end) begin
      slot_q <= exec ? 2'd0 : slot_q + 2'd1;
      if (exec && !run_in) state_q <= dmx_pkg::ST_IDLE;
    end
  end

  // Instruction bytes and code lookup capture
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_q <= `DMX_BYTE_RST;
      b1_q <= `DMX_BYTE_RST;
      b2_q <= `DMX_BYTE_RST;
      xcap_q <= `DMX_BYTE_RST;
    end else if (slot_end && slot_kind == dmx_pkg::SL_FETCH) begin
      if (slot_q == 2'd0) op_q <= p0_in;
      if (slot_q == 2'd1) b1_q <= p0_in;
      if (slot_q == 2'd2) b2_q <= p0_in;
    end else if (slot_end && slot_kind == dmx_pkg::SL_CODE) begin
      xcap_q <= p0_in; // RQ13
    end
  end

  // Program counter: advances past every fetched byte
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pc_q <= `DMX_PC_RST;
    end else if (!run_act && load_in) begin
      pc_q <= load_pc_in;
    end else if (slot_end && slot_kind == dmx_pkg::SL_FETCH) begin
      pc_q <= pc_q + 16'h0001; // RQ9
    end
  end

  // Accumulator, pointer and flags
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q <= `DMX_ACC_RST;
      par_q <= 1'b0;
      car_q <= 1'b0;
      ptr_q <= `DMX_PTR_RST;
    end else if (!run_act && load_in) begin
      acc_q <= load_acc_in;
      par_q <= ^load_acc_in;
      car_q <= load_carry_in;
      ptr_q <= load_ptr_in;
    end else if (exec && (kind == dmx_pkg::K_CPTR || kind == dmx_pkg::K_CPC)) begin
      acc_q <= xcap_q; // RQ7
      par_q <= ^xcap_q; // RQ12
    end
  end

  // Bus pins, one clock behind the phase that sets them
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      p0_q <= `DMX_BYTE_RST;
      p2_q <= `DMX_BYTE_RST;
      oe_n_q <= 1'b1;
      ale_q <= 1'b0;
      crd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else if (!run_act || slot_kind == dmx_pkg::SL_NONE) begin
      oe_n_q <= 1'b1;
      ale_q <= 1'b0;
      crd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else if (phase == 2'd0) begin
      p0_q <= bus_addr[7:0]; // RQ8
      p2_q <= bus_addr[15:8]; // RQ8
      oe_n_q <= 1'b0;
      ale_q <= 1'b1;
    end else if (phase == 2'd3) begin
      crd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end else begin
      ale_q <= 1'b0;
      if (slot_kind == dmx_pkg::SL_XWR) begin
        p0_q <= acc_q; // RQ10
        wr_n_q <= 1'b0;
      end else begin
        oe_n_q <= 1'b1;
        crd_n_q <= 1'b0;
      end
    end
  end

  // Memory view while idle, and length counter
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dbg_q <= `DMX_BYTE_RST;
      icnt_q <= 8'h00;
    end else begin
      dbg_q <= run_act ? dbg_q : rd_b;
      icnt_q <= (!run_act || exec) ? 8'h00 : icnt_q + 8'h01;
    end
  end

  assign ram_rdata_out = dbg_q;
  assign p0_out = p0_q;
  assign p0_oe_n_out = oe_n_q;
  assign p2_out = p2_q;
  assign ale_out = ale_q;
  assign code_rd_n_out = crd_n_q;
  assign data_wr_n_out = wr_n_q;
  assign acc_out = acc_q;
  assign carry_out = car_q;
  assign parity_out = par_q;
  assign sixteen_bit_pointer_out = ptr_q;
  assign pc_out = pc_q;
  assign busy_out = state_q == dmx_pkg::ST_RUN;

  chk_carry_store: assert property ( // RQ1
    @(posedge clk_in) disable iff (!rstn_in)
    exec && kind == dmx_pkg::K_STC |-> ram_we && ram_waddr == bit_byte
      && ram_wdata[b1_q[2:0]] == car_q && icnt_q == 8'(4 * SC - 1))
    else $error("carry bit store wrong");

  chk_imm_write: assert property ( // RQ2
    @(posedge clk_in) disable iff (!rstn_in)
    exec && op_q == `DMX_OP_DIR_IMM |-> ram_waddr == b1_q && ram_wdata == b2_q
      && icnt_q == 8'(4 * SC - 1))
    else $error("immediate move wrong");

  chk_ind_write: assert property ( // RQ3
    @(posedge clk_in) disable iff (!rstn_in)
    exec && kind == dmx_pkg::K_DIRIND |-> ram_we && addr_b == rd_a && ram_wdata == rd_b)
    else $error("indirect move wrong");

  chk_acc_one_cycle: assert property ( // RQ4
    @(posedge clk_in) disable iff (!rstn_in)
    exec && op_q == `DMX_OP_DIR_ACC |-> ram_we && ram_waddr == p0_in && ram_wdata == acc_q
      && icnt_q == 8'(2 * SC - 1))
    else $error("accumulator store wrong");

  chk_dir_copy: assert property ( // RQ6
    @(posedge clk_in) disable iff (!rstn_in)
    exec && kind == dmx_pkg::K_DIRDIR |-> ram_waddr == b2_q && addr_b == b1_q)
    else $error("direct copy wrong");

  chk_lookup_addr: assert property ( // RQ8
    @(posedge clk_in) disable iff (!rstn_in)
    run_act && slot_q == 2'd2 && phase == 2'd1 && kind == dmx_pkg::K_CPTR
      |-> ale_out && {p2_out, p0_out} == ptr_q + {8'h00, acc_q}
      ##2 !code_rd_n_out && p0_oe_n_out)
    else $error("lookup address wrong");

  chk_xwrite_data: assert property ( // RQ10
    @(posedge clk_in) disable iff (!rstn_in)
    run_act && slot_q == 2'd2 && phase == 2'd2 && kind == dmx_pkg::K_XPTR
      |-> !data_wr_n_out && !p0_oe_n_out && p0_out == acc_q && p2_out == ptr_q[15:8])
    else $error("external write wrong");

  chk_xreg_high: assert property ( // RQ11
    @(posedge clk_in) disable iff (!rstn_in)
    run_act && slot_q == 2'd2 && phase == 2'd1 && kind == dmx_pkg::K_XREG
      |-> ale_out && p2_out == rd_c && p0_out == rd_a)
    else $error("register address wrong");

  chk_parity_track: assert property ( // RQ12
    @(posedge clk_in) disable iff (!rstn_in)
    parity_out == ^acc_out)
    else $error("parity flag stale");
endmodule

// ---- testbench/dmx_ext_mem.sv ----
// External code and data memory model on ports 0 and 2
`timescale 1ns/1ps
module dmx_ext_mem (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ale_in,
  input wire logic [7:0] bus_in,
  input wire logic [7:0] p2_in,
  input wire logic code_rd_n_in,
  input wire logic data_wr_n_in,
  output logic [7:0] drv_out,
  output logic ev_out,
  output logic [24:0] ev_val_out
);
  logic [7:0] code [logic [15:0]];
  logic [15:0] addr_q;
  logic [7:0] last_q;
  logic strb_q;
  function automatic logic [7:0] rd(input logic [15:0] a);
    return code.exists(a) ? code[a] : 8'hFF;
  endfunction
  // Code byte while the read strobe is low, else the inverse of the last level
  assign drv_out = !code_rd_n_in ? rd(addr_q) : ~last_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_q <= 16'h0000;
      last_q <= 8'h00;
      strb_q <= 1'b0;
      ev_out <= 1'b0;
      ev_val_out <= 25'h0000000;
    end else begin
      last_q <= bus_in;
      strb_q <= !(code_rd_n_in && data_wr_n_in);
      ev_out <= 1'b0;
      if (ale_in) begin
        addr_q <= {p2_in, bus_in};
      end
      // Log each code read and each data write once per strobe
      if (!code_rd_n_in && !strb_q) begin
        ev_out <= 1'b1;
        ev_val_out <= {1'b0, addr_q, rd(addr_q)};
      end
      if (!data_wr_n_in && !strb_q) begin
        ev_out <= 1'b1;
        ev_val_out <= {1'b1, addr_q, bus_in};
      end
    end
  end
endmodule

// ---- testbench/dmx_core_tb.sv ----
// Self-checking bench for the data-move executor
`timescale 1ns/1ps
module dmx_core_tb;
  logic clk, rstn, run, load, cy_in, we, ale, crd, dwr, oen, cy, par, busy, ev;
  logic [7:0] acc_in, raddr, wdata, rdata, p0o, p2, acc, drv, p0w, a, d, v;
  logic [15:0] ptr_in, pc_in, ptr, pc_o, pcv, p;
  logic [24:0] ev_val;
  logic [24:0] expq [$];
  int failures = 0;
  int compares = 0;
  int cyc_n = 0;
  int seed_v;
  logic [7:0] bit_a [2] = '{8'h7F, 8'hE3};
  logic [7:0] byte_a [2] = '{8'h2F, 8'hE0};
  logic [7:0] pre_v [2] = '{8'h26, 8'hFF};
  logic [7:0] post_v [2] = '{8'hA6, 8'hF7};

  assign p0w = !oen ? p0o : drv;

  dmx_core dut (.clk_in(clk), .rstn_in(rstn), .run_in(run), .load_in(load),
    .load_acc_in(acc_in), .load_ptr_in(ptr_in), .load_pc_in(pc_in), .load_carry_in(cy_in),
    .ram_we_in(we), .ram_addr_in(raddr), .ram_wdata_in(wdata), .ram_rdata_out(rdata),
    .p0_in(p0w), .p0_out(p0o), .p0_oe_n_out(oen), .p2_out(p2), .ale_out(ale),
    .code_rd_n_out(crd), .data_wr_n_out(dwr), .acc_out(acc), .carry_out(cy),
    .parity_out(par), .sixteen_bit_pointer_out(ptr), .pc_out(pc_o), .busy_out(busy));

  dmx_ext_mem ext_mem (.clk_in(clk), .rstn_in(rstn), .ale_in(ale), .bus_in(p0w),
    .p2_in(p2), .code_rd_n_in(crd), .data_wr_n_in(dwr), .drv_out(drv), .ev_out(ev),
    .ev_val_out(ev_val));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (failures == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [24:0] seen, input logic [24:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic ld(input logic [7:0] av, input logic [15:0] pv, input logic c);
    @(negedge clk);
    load = 1'b1;
    acc_in = av;
    ptr_in = pv;
    pc_in = pcv;
    cy_in = c;
    @(negedge clk);
    load = 1'b0;
  endtask

  task automatic ram_wr(input logic [7:0] ad, input logic [7:0] dv);
    @(negedge clk);
    we = 1'b1;
    raddr = ad;
    wdata = dv;
    @(negedge clk);
    we = 1'b0;
  endtask

  task automatic ram_chk(input logic [7:0] ad, input logic [7:0] dv);
    @(negedge clk);
    raddr = ad;
    @(negedge clk);
    check(25'(rdata), 25'(dv));
  endtask

  // Places the instruction at pcv, notes its fetches, runs it once
  task automatic exec(input logic [23:0] b, input int n, input int cyc, input logic [24:0] e);
    int cnt;
    for (int i = 0; i < n; i++) begin
      ext_mem.code[pcv + 16'(i)] = b[23-8*i -: 8];
      expq.push_back({1'b0, pcv + 16'(i), b[23-8*i -: 8]});
    end
    if (e !== 25'h0000000) expq.push_back(e);
    @(negedge clk);
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
    cnt = 0;
    while (busy === 1'b1 && cnt < 100) begin
      cnt++;
      @(negedge clk);
    end
    check(25'(cnt), 25'(cyc * 8));
    pcv = pcv + 16'(n);
    check(25'(pc_o), 25'(pcv));
  endtask

  always @(posedge clk) begin
    if (ev) begin
      if (expq.size() == 0) check(ev_val, 25'h1FFFFFF);
      else check(ev_val, expq.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      failures++;
      summarize();
    end
  end

  initial begin
    rstn = 1'b0;
    {run, load, cy_in, we} = 4'h0;
    {acc_in, raddr, wdata} = 24'h000000;
    {ptr_in, pc_in} = 32'h00000000;
    pcv = 16'h0100;
    seed_v = $urandom(32'hA7F46E32);
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    check({p2, p0o, oen, ale, crd, dwr, busy}, {8'h00, 8'h00, 5'h16});
    ld(8'h00, 16'h0000, 1'b0);
    exec({8'h00, 16'h0000}, 1, 1, 25'h0);
    for (int i = 0; i < 3; i++) begin
      d = 8'h40 + (8'($urandom) & 8'h3F);
      v = 8'($urandom);
      exec({8'h75, d, v}, 3, 2, 25'h0);
      ram_chk(d, v);
      a = 8'($urandom);
      ld(a, 16'h0000, i[0]);
      exec({8'hF5, d ^ 8'h20, 8'h00}, 2, 1, 25'h0);
      ram_chk(d ^ 8'h20, a);
      check({cy, par}, {i[0], ^a});
    end
    for (int r = 0; r < 8; r++) begin
      v = 8'($urandom);
      ram_wr(8'(r), v);
      exec({8'h88 | 8'(r), 8'h50 + 8'(r), 8'h00}, 2, 2, 25'h0);
      ram_chk(8'h50 + 8'(r), v);
    end
    for (int r = 0; r < 2; r++) begin
      v = 8'($urandom);
      ram_wr(8'(r), 8'h10 + 8'(r));
      ram_wr(8'h10 + 8'(r), v);
      exec({8'h86 | 8'(r), 8'h60, 8'h00}, 2, 2, 25'h0);
      ram_chk(8'h60, v);
    end
    v = 8'($urandom);
    ram_wr(8'h18, v);
    exec({8'h85, 8'h18, 8'h7E}, 3, 2, 25'h0);
    ram_chk(8'h7E, v);
    ram_chk(8'h18, v);
    for (int k = 0; k < 2; k++) begin
      ld(8'h00, 16'h0000, !k[0]);
      ram_wr(byte_a[k], pre_v[k]);
      exec({8'h92, bit_a[k], 8'h00}, 2, 2, 25'h0);
      ram_chk(byte_a[k], post_v[k]);
      check(25'(cy), 25'(!k[0]));
    end
    for (int i = 0; i < 3; i++) begin
      a = 8'($urandom);
      p = {8'h40, 8'($urandom)};
      v = 8'($urandom);
      ext_mem.code[p + 16'(a)] = v;
      ld(a, p, 1'b0);
      exec({8'h93, 16'h0000}, 1, 2, {1'b0, p + 16'(a), v});
      check({acc, par}, {v, ^v});
    end
    a = 8'h80 | 8'($urandom);
    v = 8'($urandom);
    ext_mem.code[pcv + 16'h0001 + 16'(a)] = v;
    ld(a, 16'h0000, 1'b0);
    exec({8'h83, 16'h0000}, 1, 2, {1'b0, pcv + 16'h0001 + 16'(a), v});
    check({acc, par}, {v, ^v});
    a = 8'($urandom);
    p = 16'($urandom);
    ld(a, p, 1'b1);
    exec({8'hF0, 16'h0000}, 1, 2, {1'b1, p, a});
    check({acc, cy, par}, {a, 1'b1, ^a});
    check(25'(ptr), 25'(p));
    for (int r = 0; r < 2; r++) begin
      d = 8'($urandom);
      v = 8'($urandom);
      ram_wr(8'hA0, d);
      ram_wr(8'(r), v);
      exec({8'hF2 | 8'(r), 16'h0000}, 1, 2, {1'b1, d, v, a});
      ram_chk(8'hA0, d);
    end
    repeat (4) @(negedge clk);
    check(25'(expq.size()), 25'h0);
    summarize();
  end
endmodule
